// file: design/pii_img_mem.sv
/*
 * One 128-byte image memory, byte or word write, registered byte read.
 * Assumes a word is never written at the last byte address.
 */
`timescale 1ns/10ps
`include "pii_params.svh"
module pii_img_mem (
    input wire logic clk_i,
    input wire logic resetn_i,
    pii_mem_if.mem mem_io
);
    logic [7:0] mem_q [0:`PII_IMG_BYTES-1];
    logic [7:0] rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Write port; a word puts its high byte at the lower address
    always_ff @(posedge clk_i) begin
        if (mem_io.we) begin
            if (mem_io.wword) begin
                mem_q[mem_io.waddr] <= mem_io.wdata[15:8];
                mem_q[7'(mem_io.waddr + 7'h01)] <= mem_io.wdata[7:0];
            end else begin
                mem_q[mem_io.waddr] <= mem_io.wdata[7:0];
            end
        end
    end

    // Registered read, one cycle of latency
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= mem_q[mem_io.raddr];
        end
    end

    assign mem_io.rdata = rdata_q;
endmodule : pii_img_mem

// file: design/pii_mem_if.sv
/*
 * Port bundle between the unit and one image memory.
 * Assumes the user drives the write and read address every cycle.
 */
`timescale 1ns/10ps
interface pii_mem_if;
    logic we;
    logic wword;
    logic [6:0] waddr;
    logic [15:0] wdata;
    logic [6:0] raddr;
    logic [7:0] rdata;

    modport mem (input we, input wword, input waddr, input wdata, input raddr,
                 output rdata);
    modport user (output we, output wword, output waddr, output wdata, output raddr,
                  input rdata);
endinterface : pii_mem_if

// file: design/pii_params.svh
/*
 * Constants of the process interrupt image unit: image sizes, operand
 * limits, reset values and reaction-time figures.
 * Assumes a 100 MHz scan clock; included by every design file that needs it.
 */
`ifndef PII_PARAMS_SVH
`define PII_PARAMS_SVH

// Interrupt-capable channels: four per slot, slots 0 and 1
`define PII_CHANNELS 8
`define PII_NIB 4
`define PII_IMG_BYTES 128
`define PII_IDX_W 8
`define PII_IDX_END 8'h80

// Operand limits of the input image loads and output image transfers
`define PII_LD_MAX_BYTE 7'h01
`define PII_LD_MAX_WORD 7'h00
`define PII_WR_MAX_BYTE 7'h7F
`define PII_WR_MAX_WORD 7'h7E

// Reset values
`define PII_EN_RST 1'b1
`define PII_IMG_RST 16'h0000

// Reaction-time figures in microseconds, and the clock rate
`define PII_CLK_MHZ 100
`define PII_T_BASE_US 600
`define PII_T_FB_US 500
`define PII_T_CLKP_US 200
`define PII_T_NET_US 8000
`define PII_T_OUTADR_US 18000
`define PII_T_COMPRESS_US 31000
`define PII_T_MOVE_US 600000

`endif

// file: design/pii_pkg.sv
/*
 * Types of the process interrupt image unit.
 * Assumes nothing; used with explicit package scope.
 */
package pii_pkg;

    // Sequencer states, Gray coded along idle-react-service-flush
    typedef enum logic [2:0] {
        pii_st_idle = 3'h0,
        pii_st_react = 3'h1,
        pii_st_svc = 3'h3,
        pii_st_flush = 3'h2,
        pii_st_copy = 3'h4
    } pii_state_t;

endpackage : pii_pkg

// file: design/pii_unit.sv
/*
 * Process interrupt image unit: edge detection on the slot 0/1 interrupt
 * inputs, acceptance at program boundaries, reaction delay, interrupt input
 * image, dual output image writes, end-of-cycle copy and interrupt flush.
 * Assumes the CPU sequencer gives one-cycle boundary and done pulses.
 */
`timescale 1ns/10ps
`include "pii_params.svh"

// Summary of operation
// R1 - Any change of a monitored input, rising or falling, raises an interrupt.
// R2 - Only slot 0 and slot 1 inputs can raise interrupts.
// R3 - Accepted interrupt calls the service block, or resumes at once if absent.
// R4 - Pending interrupt is accepted after any single program statement.
// R5 - During a data cycle, accept only at four-bit-plus-check packet boundaries.
// R6 - Disable and enable operations exist; enabled after reset.
// R7 - Software keeps block nesting at sixteen levels or fewer.
// R8 - A second interrupt waits until the running service ends.
// R9 - Both edges while disabled: channel unknown, but service still called.
// R10 - On interrupt, sample slot 0/1 inputs into the interrupt input image.
// R11 - Image loads only byte 0, byte 1, word 0; else halt and log error.
// R12 - Sampling leaves the normal process input image untouched.
// R13 - Interrupt or timed writes update both output images together.
// R14 - After service, flush interrupt output image before normal processing.
// R15 - At main cycle end, copy normal output image into interrupt image.
// R16 - Flush runs only if the interrupt output image was written.
// R17 - Transfers accept byte addresses 0 to 127, word 0 to 126.
// R18 - Bit operations reach only the normal images.
// R19 - Basic reaction time is 0.6 ms.
// R20 - Add 0.5 ms for function blocks, 0.2 ms clock, 8.0 ms network.
// R21 - Add 18 ms per kbyte, 31 ms compression, 600 ms per kword moved.
// R22 - Edges found against a registered previous sample, pending flag per channel.
module pii_unit #(
    parameter int unsigned BASE_CYC = `PII_T_BASE_US * `PII_CLK_MHZ,
    parameter int unsigned FB_CYC = `PII_T_FB_US * `PII_CLK_MHZ,
    parameter int unsigned CLKP_CYC = `PII_T_CLKP_US * `PII_CLK_MHZ,
    parameter int unsigned NET_CYC = `PII_T_NET_US * `PII_CLK_MHZ,
    parameter int unsigned OUTADR_CYC = `PII_T_OUTADR_US * `PII_CLK_MHZ,
    parameter int unsigned COMPRESS_CYC = `PII_T_COMPRESS_US * `PII_CLK_MHZ,
    parameter int unsigned MOVE_CYC = `PII_T_MOVE_US * `PII_CLK_MHZ
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [`PII_CHANNELS-1:0] irq_in_i,
    input wire logic stmt_done_i,
    input wire logic data_cycle_i,
    input wire logic packet_done_i,
    input wire logic svc_present_i,
    input wire logic svc_done_i,
    input wire logic irq_disable_op_i,
    input wire logic irq_enable_op_i,
    input wire logic main_cycle_end_i,
    input wire logic use_fb_i,
    input wire logic clk_param_i,
    input wire logic serial_net_i,
    input wire logic [3:0] out_addr_kbytes_i,
    input wire logic compress_after_reset_i,
    input wire logic [2:0] moved_kwords_i,
    input wire logic ld_req_i,
    input wire logic ld_word_i,
    input wire logic [6:0] ld_addr_i,
    input wire logic wr_req_i,
    input wire logic wr_irq_ctx_i,
    input wire logic wr_word_i,
    input wire logic [6:0] wr_addr_i,
    input wire logic [15:0] wr_data_i,
    output logic svc_call_o,
    output logic resume_o,
    output logic in_service_o,
    output logic irq_enabled_o,
    output logic irq_pending_o,
    output logic [15:0] ld_data_o,
    output logic bad_operand_error_o,
    output logic halt_o,
    output logic wr_ready_o,
    output logic wr_reject_o,
    output logic out_valid_o,
    output logic [6:0] out_addr_o,
    output logic [7:0] out_data_o
);
    pii_pkg::pii_state_t state_q;
    logic [`PII_CHANNELS-1:0] prev_q;
    logic [`PII_CHANNELS-1:0] pend_q;
    logic [`PII_CHANNELS-1:0] edge_w;
    logic prime_q;
    logic en_q;
    logic halt_q;
    logic dirty_q;
    logic copy_pend_q;
    logic [15:0] iimg_q;
    logic [31:0] react_cnt_q;
    logic [31:0] react_total_w;
    logic [`PII_IDX_W-1:0] idx_q;
    logic rd_vld_q;
    logic [6:0] rd_idx_q;
    logic boundary_w;
    logic accept_w;
    logic ld_ok_w;
    logic wr_ok_w;
    logic wr_irq_w;
    logic dirty_any_w;
    logic scan_w;
    logic scan_done_w;

    pii_mem_if nrm_if();
    pii_mem_if irq_if();

    // Operand legality shared by loads and transfers
    function automatic logic operand_ok(input logic word, input logic [6:0] addr,
                                        input logic [6:0] max_b, input logic [6:0] max_w);
        operand_ok = word ? (addr <= max_w) : (addr <= max_b);
    endfunction : operand_ok

    // Total reaction budget from the running functions
    function automatic logic [31:0] react_total(input logic fb, input logic clkp,
                                                input logic net, input logic [3:0] kb,
                                                input logic cmp, input logic [2:0] kw);
        react_total = 32'(BASE_CYC) // R19
                    + (fb ? 32'(FB_CYC) : 32'h0) + (clkp ? 32'(CLKP_CYC) : 32'h0) // R20
                    + (net ? 32'(NET_CYC) : 32'h0) // R20
                    + 32'(kb) * 32'(OUTADR_CYC) // R21
                    + (cmp ? 32'(COMPRESS_CYC) : 32'h0) // R21
                    + 32'(kw) * 32'(MOVE_CYC); // R21
    endfunction : react_total

    ////////////////////////////////////////////////////////////////////////
    // Edge detection; only slot 0/1 lines exist on this port
    // First cycle after reset only primes, so a high line is no false edge
    assign edge_w = (irq_in_i ^ prev_q) & {`PII_CHANNELS{prime_q}}; // R1 R2 R22

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            prev_q <= '0;
            prime_q <= 1'b0;
        end else begin
            prev_q <= irq_in_i; // R22
            prime_q <= 1'b1;
        end
    end

    // Pending flags: a new edge beats the clear of acceptance
    // Two edges while disabled leave one flag, so the service still runs
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pend_q <= '0;
        end else begin
            pend_q <= (accept_w ? '0 : pend_q) | edge_w; // R8 R9 R22
        end
    end

    // Global enable, disable wins when both arrive together
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            en_q <= `PII_EN_RST; // R6
        end else if (irq_disable_op_i) begin
            en_q <= 1'b0; // R6
        end else if (irq_enable_op_i) begin
            en_q <= 1'b1; // R6
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Acceptance point: packet edge in a data cycle, else statement end
    assign boundary_w = data_cycle_i ? packet_done_i : stmt_done_i; // R4 R5
    assign accept_w = (state_q == pii_pkg::pii_st_idle) && en_q && !halt_q
                    && (|pend_q) && boundary_w; // R8
    assign react_total_w = react_total(use_fb_i, clk_param_i, serial_net_i,
                                       out_addr_kbytes_i, compress_after_reset_i,
                                       moved_kwords_i);
    assign wr_ready_o = (state_q != pii_pkg::pii_st_copy)
                      && (state_q != pii_pkg::pii_st_flush);
    assign wr_ok_w = wr_req_i && wr_ready_o && operand_ok(wr_word_i, wr_addr_i,
                     `PII_WR_MAX_BYTE, `PII_WR_MAX_WORD); // R17
    assign wr_irq_w = wr_ok_w && wr_irq_ctx_i;
    assign dirty_any_w = dirty_q || wr_irq_w;
    assign scan_w = idx_q != `PII_IDX_END;
    assign scan_done_w = !scan_w && !rd_vld_q;

    // Sequencer; the reaction counter only runs while a call is due
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state_q <= pii_pkg::pii_st_idle;
            react_cnt_q <= 32'h0;
            svc_call_o <= 1'b0;
            resume_o <= 1'b0;
        end else begin
            svc_call_o <= 1'b0;
            resume_o <= 1'b0;
            case (state_q)
                pii_pkg::pii_st_idle: begin
                    if (accept_w && svc_present_i) begin
                        state_q <= pii_pkg::pii_st_react; // R3
                        react_cnt_q <= react_total_w - 32'h1;
                    end else if (accept_w) begin
                        resume_o <= 1'b1; // R3
                    end else if (copy_pend_q) begin
                        state_q <= pii_pkg::pii_st_copy; // R15
                    end
                end
                pii_pkg::pii_st_react: begin
                    if (react_cnt_q == 32'h0) begin
                        state_q <= pii_pkg::pii_st_svc;
                        svc_call_o <= 1'b1; // R3 R19
                    end else begin
                        react_cnt_q <= react_cnt_q - 32'h1;
                    end
                end
                pii_pkg::pii_st_svc: begin
                    if (svc_done_i && dirty_any_w) begin
                        state_q <= pii_pkg::pii_st_flush; // R14 R16
                    end else if (svc_done_i) begin
                        state_q <= pii_pkg::pii_st_idle; // R16
                        resume_o <= 1'b1;
                    end
                end
                pii_pkg::pii_st_flush: begin
                    if (scan_done_w) begin
                        state_q <= pii_pkg::pii_st_idle; // R14
                        resume_o <= 1'b1;
                    end
                end
                pii_pkg::pii_st_copy: begin
                    if (scan_done_w) begin
                        state_q <= pii_pkg::pii_st_idle;
                    end
                end
                default: begin
                    state_q <= pii_pkg::pii_st_idle;
                end
            endcase
        end
    end

    // Copy request waits out a service in progress; new request beats clear
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            copy_pend_q <= 1'b0;
        end else begin
            copy_pend_q <= main_cycle_end_i || (copy_pend_q && (state_q != pii_pkg::pii_st_idle
                           || accept_w)); // R15
        end
    end

    // Dirty mark: interrupt image written by the running service
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            dirty_q <= 1'b0;
        end else if (state_q == pii_pkg::pii_st_svc && !svc_done_i) begin
            dirty_q <= dirty_any_w; // R16
        end else begin
            dirty_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte scan shared by copy and flush; reads lag one cycle
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            idx_q <= `PII_IDX_END;
            rd_vld_q <= 1'b0;
            rd_idx_q <= 7'h00;
        end else begin
            rd_vld_q <= 1'b0;
            if ((state_q == pii_pkg::pii_st_idle && copy_pend_q && !accept_w)
                || (state_q == pii_pkg::pii_st_svc && svc_done_i && dirty_any_w)) begin
                idx_q <= '0;
            end else if (scan_w && (state_q == pii_pkg::pii_st_copy
                         || state_q == pii_pkg::pii_st_flush)) begin
                idx_q <= `PII_IDX_W'(idx_q + `PII_IDX_W'(1));
                rd_vld_q <= 1'b1;
                rd_idx_q <= idx_q[6:0];
            end
        end
    end

    // Normal image: every accepted transfer lands here
    assign nrm_if.we = wr_ok_w;
    assign nrm_if.wword = wr_word_i;
    assign nrm_if.waddr = wr_addr_i;
    assign nrm_if.wdata = wr_data_i;
    assign nrm_if.raddr = idx_q[6:0];

    // Interrupt image: context writes in parallel, or the copy stream
    // Copy never collides with software since writes stall meanwhile
    assign irq_if.we = wr_irq_w || (state_q == pii_pkg::pii_st_copy && rd_vld_q); // R13 R15
    assign irq_if.wword = wr_irq_w ? wr_word_i : 1'b0;
    assign irq_if.waddr = wr_irq_w ? wr_addr_i : rd_idx_q;
    assign irq_if.wdata = wr_irq_w ? wr_data_i : {8'h00, nrm_if.rdata};
    assign irq_if.raddr = idx_q[6:0];

    pii_img_mem u_nrm_img (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .mem_io(nrm_if)
    );

    pii_img_mem u_irq_img (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .mem_io(irq_if)
    );

    // Flush stream towards the peripherals
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            out_valid_o <= 1'b0;
            out_addr_o <= 7'h00;
            out_data_o <= 8'h00;
        end else begin
            out_valid_o <= (state_q == pii_pkg::pii_st_flush) && rd_vld_q; // R14
            out_addr_o <= rd_idx_q;
            out_data_o <= irq_if.rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt input image: own register, the normal input image is
    // elsewhere and never written from here; byte 0 slot 0, byte 1 slot 1
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            iimg_q <= `PII_IMG_RST;
        end else if (accept_w) begin
            iimg_q <= {4'h0, irq_in_i[`PII_NIB-1:0], 4'h0,
                       irq_in_i[`PII_CHANNELS-1:`PII_NIB]}; // R10 R12
        end
    end

    // Loads: byte and word only, no bit path into the interrupt images
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ld_data_o <= 16'h0000;
            bad_operand_error_o <= 1'b0;
            halt_q <= 1'b0;
            wr_reject_o <= 1'b0;
        end else begin
            bad_operand_error_o <= ld_req_i && !ld_ok_w; // R11
            wr_reject_o <= wr_req_i && wr_ready_o && !wr_ok_w; // R17
            if (ld_req_i && !ld_ok_w) begin
                halt_q <= 1'b1; // R11
            end
            if (ld_req_i && ld_ok_w) begin
                ld_data_o <= ld_word_i ? iimg_q : (ld_addr_i[0] ? {8'h00, iimg_q[7:0]}
                             : {8'h00, iimg_q[15:8]}); // R18
            end
        end
    end

    assign ld_ok_w = operand_ok(ld_word_i, ld_addr_i, `PII_LD_MAX_BYTE, `PII_LD_MAX_WORD);
    assign halt_o = halt_q;
    assign in_service_o = state_q == pii_pkg::pii_st_svc;
    assign irq_enabled_o = en_q;
    assign irq_pending_o = |pend_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_edge_pend;
        @(posedge clk_i) disable iff (!resetn_i) (|edge_w) |=> (|pend_q);
    endproperty
    a_edge_pend: assert property (p_edge_pend) else $error("edge lost"); // R1

    property p_accept_bound;
        @(posedge clk_i) disable iff (!resetn_i)
            (state_q == pii_pkg::pii_st_idle ##1 state_q == pii_pkg::pii_st_react)
            |-> $past(boundary_w) && $past(en_q);
    endproperty
    a_accept_bound: assert property (p_accept_bound) else $error("bad accept point"); // R4

    property p_no_svc;
        @(posedge clk_i) disable iff (!resetn_i) (accept_w && !svc_present_i)
            |=> resume_o && state_q == pii_pkg::pii_st_idle;
    endproperty
    a_no_svc: assert property (p_no_svc) else $error("no resume without service"); // R3

    property p_held;
        @(posedge clk_i) disable iff (!resetn_i)
            (state_q == pii_pkg::pii_st_svc && (|pend_q)) |=> (|pend_q);
    endproperty
    a_held: assert property (p_held) else $error("nested request dropped"); // R8

    property p_image;
        @(posedge clk_i) disable iff (!resetn_i) accept_w |=>
            iimg_q == {4'h0, $past(irq_in_i[3:0]), 4'h0, $past(irq_in_i[7:4])};
    endproperty
    a_image: assert property (p_image) else $error("input image wrong"); // R10

    property p_bad_ld;
        @(posedge clk_i) disable iff (!resetn_i) (ld_req_i && !ld_ok_w)
            |=> bad_operand_error_o && halt_o ##1 halt_o;
    endproperty
    a_bad_ld: assert property (p_bad_ld) else $error("bad operand not caught"); // R11

    property p_dual;
        @(posedge clk_i) disable iff (!resetn_i)
            (wr_ok_w && wr_irq_ctx_i) |-> nrm_if.we && irq_if.we
            && irq_if.waddr == nrm_if.waddr;
    endproperty
    a_dual: assert property (p_dual) else $error("images not written together"); // R13

    property p_flush;
        @(posedge clk_i) disable iff (!resetn_i)
            (state_q == pii_pkg::pii_st_svc && svc_done_i && dirty_any_w)
            |=> !resume_o ##[128:132] resume_o;
    endproperty
    a_flush: assert property (p_flush) else $error("flush length wrong"); // R14

    property p_skip;
        @(posedge clk_i) disable iff (!resetn_i)
            (state_q == pii_pkg::pii_st_svc && svc_done_i && !dirty_any_w)
            |=> resume_o ##1 !out_valid_o;
    endproperty
    a_skip: assert property (p_skip) else $error("flush not skipped"); // R16

    property p_word_limit;
        @(posedge clk_i) disable iff (!resetn_i)
            (wr_req_i && wr_ready_o && wr_word_i && wr_addr_i == 7'h7F)
            |-> !nrm_if.we ##1 wr_reject_o;
    endproperty
    a_word_limit: assert property (p_word_limit) else $error("word 127 taken"); // R17

    property p_react;
        @(posedge clk_i) disable iff (!resetn_i)
            (state_q == pii_pkg::pii_st_idle ##1 state_q == pii_pkg::pii_st_react)
            |-> react_cnt_q == $past(react_total_w) - 32'h1;
    endproperty
    a_react: assert property (p_react) else $error("reaction budget wrong"); // R19 R20 R21
endmodule : pii_unit

// file: tb/pii_io_model.sv
/* Model of the slot 0/1 four-channel input modules.
   Assumes the bench sets wanted levels just after a clock edge. */
`timescale 1ns/10ps
module pii_io_model (
    input wire logic clk_i,
    input wire logic slow_i,
    input wire logic [7:0] lvl_i,
    output logic [7:0] irq_o
);
    logic [7:0] d_q [3];
    // Module signal delay; slow mode stands in for a lagging module
    always_ff @(posedge clk_i) begin
        d_q <= '{lvl_i, d_q[0], d_q[1]};
    end
    assign irq_o = slow_i ? d_q[2] : d_q[0];
endmodule : pii_io_model

// file: tb/tb_process_interrupt_image_unit.sv
/* Bench for the interrupt image unit, reaction counts shortened.
   Assumes the design files and the module model compile first. */
`timescale 1ns/10ps
module tb_process_interrupt_image_unit;
    logic clk_i = 0, resetn_i = 0, stmt_done_i = 0, data_cycle_i = 0, packet_done_i = 0;
    logic svc_present_i = 1, svc_done_i = 0, irq_disable_op_i = 0, irq_enable_op_i = 0;
    logic main_cycle_end_i = 0, use_fb_i = 0, clk_param_i = 0, serial_net_i = 0;
    logic compress_after_reset_i = 0, ld_req_i = 0, ld_word_i = 0, wr_req_i = 0;
    logic wr_irq_ctx_i = 0, wr_word_i = 0, slow = 0, svc_call_o, resume_o, in_service_o;
    logic irq_enabled_o, irq_pending_o, bad_operand_error_o, halt_o, wr_ready_o;
    logic wr_reject_o, out_valid_o;
    logic [3:0] out_addr_kbytes_i = 0;
    logic [2:0] moved_kwords_i = 0;
    logic [6:0] ld_addr_i = 0, wr_addr_i = 0, out_addr_o;
    logic [7:0] lvl = 0, irq_in_i, out_data_o;
    logic [15:0] wr_data_i = 0, ld_data_o;
    int err_total = 0, n_tests = 0;

    // 100 MHz scan clock
    always #5 clk_i = ~clk_i;
    pii_io_model i_io (.clk_i, .slow_i(slow), .lvl_i(lvl), .irq_o(irq_in_i));
    // Small counts keep each reaction delay a few cycles long
    pii_unit #(.BASE_CYC(5), .FB_CYC(2), .CLKP_CYC(1), .NET_CYC(3), .OUTADR_CYC(2),
        .COMPRESS_CYC(4), .MOVE_CYC(3)) i_dut (.clk_i, .resetn_i, .irq_in_i,
        .stmt_done_i, .data_cycle_i, .packet_done_i, .svc_present_i, .svc_done_i,
        .irq_disable_op_i, .irq_enable_op_i, .main_cycle_end_i, .use_fb_i, .clk_param_i,
        .serial_net_i, .out_addr_kbytes_i, .compress_after_reset_i, .moved_kwords_i,
        .ld_req_i, .ld_word_i, .ld_addr_i, .wr_req_i, .wr_irq_ctx_i, .wr_word_i,
        .wr_addr_i, .wr_data_i, .svc_call_o, .resume_o, .in_service_o, .irq_enabled_o,
        .irq_pending_o, .ld_data_o, .bad_operand_error_o, .halt_o, .wr_ready_o,
        .wr_reject_o, .out_valid_o, .out_addr_o, .out_data_o);

    // Inputs move 1 ns after the edge, so no race with sampling
    task automatic cyc(int n = 1);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc
    task automatic chk(logic [15:0] s, logic [15:0] e);
        n_tests++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic end_of_test;
        $display("errors %0d checks %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test
    // Strobe k: statement, packet, service done, disable, enable, cycle end
    task automatic stb(int k, logic v);
        case (k)
            0: stmt_done_i = v;
            1: packet_done_i = v;
            2: svc_done_i = v;
            3: irq_disable_op_i = v;
            4: irq_enable_op_i = v;
            default: main_cycle_end_i = v;
        endcase
    endtask : stb
    task automatic pulse(int k);
        stb(k, 1);
        cyc();
        stb(k, 0);
    endtask : pulse
    task automatic edge_to(logic [7:0] v);
        lvl = v;
        cyc(2);
        chk(irq_pending_o, 1);
    endtask : edge_to
    // Boundary pulse, then cycles until the service call
    task automatic acc(logic pkt, int e);
        int n;
        n = 0;
        pulse(pkt ? 1 : 0);
        while (svc_call_o !== 1'b1 && n < 99) begin
            cyc();
            n++;
        end
        chk(n[15:0], e[15:0]);
        chk(in_service_o, 1);
    endtask : acc
    task automatic done;
        // Service nests no blocks, well inside the nesting limit
        pulse(2);
        chk(resume_o, 1);
    endtask : done
    task automatic ld(logic w, logic [6:0] a, logic [15:0] e);
        {ld_req_i, ld_word_i, ld_addr_i} = {1'b1, w, a};
        cyc();
        ld_req_i = 0;
        chk(ld_data_o, e);
        cyc();
    endtask : ld
    task automatic wr(logic c, logic w, logic [6:0] a, logic [15:0] d, logic rj);
        {wr_req_i, wr_irq_ctx_i, wr_word_i, wr_addr_i, wr_data_i} = {1'b1, c, w, a, d};
        cyc();
        wr_req_i = 0;
        chk(wr_reject_o, rj);
        cyc();
    endtask : wr
    ////////////////////////////////////////////////////////////////////////////////
    // Both edges, nesting and image loads
    task automatic t_basic;
        chk(irq_enabled_o, 1);
        edge_to(8'h01);
        acc(0, 5);
        ld(1, 7'h00, 16'h0100);
        ld(0, 7'h01, 16'h0000);
        done();
        edge_to(8'h00);
        acc(0, 5);
        edge_to(8'h10);
        chk(svc_call_o, 0);
        done();
        acc(0, 5);
        ld(0, 7'h01, 16'h0001);
        done();
    endtask : t_basic
    // Copy at cycle end, dirty writes, then flush of all 128 bytes
    task automatic t_flush;
        logic [7:0] img [128];
        int n;
        int c;
        {n, c} = 0;
        wr(0, 0, 7'h09, 16'h005A, 0);
        pulse(5);
        cyc(3);
        chk(wr_ready_o, 0);
        while (wr_ready_o !== 1'b1 && n < 300) begin
            cyc();
            n++;
        end
        chk(wr_ready_o, 1);
        edge_to(8'h00);
        acc(0, 5);
        wr(1, 0, 7'h05, 16'h00A7, 0);
        wr(1, 1, 7'h7E, 16'h1234, 0);
        wr(1, 1, 7'h7F, 16'h5678, 1);
        pulse(2);
        while (resume_o !== 1'b1 && n < 700) begin
            if (out_valid_o === 1'b1) begin
                c++;
                img[out_addr_o] = out_data_o;
            end
            cyc();
            n++;
        end
        chk(c[15:0], 16'd128);
        chk({img[9], img[5]}, 16'h5AA7);
        chk({img[126], img[127]}, 16'h1234);
    endtask : t_flush
    // Disabled window with both edges, lagging module
    task automatic t_dis;
        pulse(3);
        chk(irq_enabled_o, 0);
        slow = 1;
        lvl = 8'h02;
        cyc(4);
        lvl = 8'h00;
        cyc(4);
        pulse(0);
        cyc(8);
        chk({in_service_o, irq_pending_o}, 1);
        pulse(4);
        slow = 0;
        acc(0, 5);
        done();
    endtask : t_dis
    // All reaction adders: 5+2+1+3+2*2+4+3
    task automatic t_rt;
        {use_fb_i, clk_param_i, serial_net_i, compress_after_reset_i} = 4'hF;
        {out_addr_kbytes_i, moved_kwords_i} = {4'h2, 3'h1};
        edge_to(8'h08);
        acc(0, 22);
        done();
        {use_fb_i, clk_param_i, serial_net_i, compress_after_reset_i} = 4'h0;
        {out_addr_kbytes_i, moved_kwords_i} = 0;
    endtask : t_rt
    // Packet boundaries, absent service block, bad operand
    task automatic t_misc;
        data_cycle_i = 1;
        edge_to(8'h00);
        pulse(0);
        cyc(3);
        chk(in_service_o, 0);
        acc(1, 5);
        done();
        data_cycle_i = 0;
        svc_present_i = 0;
        edge_to(8'h01);
        pulse(0);
        chk(resume_o, 1);
        svc_present_i = 1;
        {ld_req_i, ld_word_i, ld_addr_i} = {2'b10, 7'h02};
        cyc();
        ld_req_i = 0;
        chk({bad_operand_error_o, halt_o}, 16'h0003);
    endtask : t_misc

    // Main sequence
    initial begin
        cyc(16);
        resetn_i = 1;
        t_basic();
        t_flush();
        t_dis();
        t_rt();
        t_misc();
        end_of_test();
    end
    // Watchdog well beyond the expected run
    initial begin
        #100000;
        err_total++;
        end_of_test();
    end
endmodule : tb_process_interrupt_image_unit
